// File: core/sleep_wdt_pkg.sv
`default_nettype none
package sleep_wdt_pkg;
   // Register byte addresses (offset 0x2007 is not a multiple of four: index times four)
   localparam logic [15:0] option_index = 16'h0081;
   localparam logic [15:0] config_index = 16'h2007;
   localparam logic [17:0] option_addr = {option_index, 2'b00};
   localparam logic [17:0] option_mirror_addr = 18'h00604;
   localparam logic [17:0] config_addr = {config_index, 2'b00};
   localparam logic [17:0] status_addr = 18'h10000;
   localparam logic [17:0] irq_status_addr = 18'h10004;
   localparam logic [17:0] irq_enable_addr = 18'h10008;
   localparam logic [17:0] irq_clear_addr = 18'h1000C;
   localparam logic [17:0] control_addr = 18'h10010;
   // Field positions
   localparam int wdt_en_pos = 2;
   localparam int psa_pos = 3;
   localparam int status_to_pos = 4;
   localparam int status_pd_pos = 3;
   localparam int status_sleep_pos = 0;
   localparam int ctrl_sleep_pos = 0;
   localparam int ctrl_clrwdt_pos = 1;
   // Reset values
   localparam logic [7:0] option_reset = 8'hFF;
   localparam logic [7:0] config_default = 8'hFF;
   // Interrupt bits
   localparam int irq_entry_pos = 0;
   localparam int irq_timeout_pos = 1;
   localparam int irq_wake_pos = 2;
   // Watchdog base period in core cycles
   localparam logic [7:0] wdt_base_ticks = 8'hFF;
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   typedef enum logic [1:0] {
      st_run = 2'b00,
      st_sleep = 2'b01,
      st_wake = 2'b10
   } power_state_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_t;
endpackage
`default_nettype wire

// File: core/sleep_and_watchdog_control.sv
`default_nettype none
// Overview of operation
// - Power-down is entered only on the core's sleep instruction strobe.
// - With the watchdog enabled, entry clears the watchdog counter and it keeps running.
// - Entry clears the power-down flag of the processor status.
// - Entry sets the time-out flag of the processor status.
// - Entry turns the oscillator driver off so the main clock stops.
// - In power-down every pin keeps its pre-sleep drive: high, low or released.
// - A watchdog expiry outside power-down resets the core internally; no expiry drives the reset pin.
// - Watchdog enable is bit 2 of the configuration word, kept across every reset except power-on.
// - Option bit 3 assigns the prescaler, bits 2..0 set its rate, all reset to one.
module sleep_and_watchdog_control #(
   parameter int wdt_width = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sleep_instr,
   input wire logic clear_wdt_instr,
   input wire logic power_on,
   input wire logic [7:0] core_pin_out,
   input wire logic [7:0] core_pin_oe,
   input wire logic external_reset_pin,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic osc_enable,
   output logic watchdog_reset,
   output logic external_reset_pin_oe,
   output logic power_down_flag,
   output logic timeout_flag,
   output logic irq
);
   sleep_wdt_pkg::power_state_t state;
   sleep_wdt_pkg::pin_drive_t held;
   logic [7:0] prescaler_option_reg;
   logic [7:0] device_configuration_word;
   logic [wdt_width-1:0] watchdog_counter;
   logic [7:0] prescale_count;
   logic [2:0] irq_status;
   logic [2:0] irq_enable;
   logic [17:0] aw_addr;
   logic aw_full;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_full;
   logic do_write;
   logic do_sleep;
   logic wdt_expire;
   logic sw_clear_wdt;
   logic [2:0] irq_events;
   logic [2:0] irq_clear;
   logic watchdog_enable_bit;
   logic prescaler_assign_bit;
   logic [2:0] prescale_rate;

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      merge_byte = strb[0] ? data[7:0] : old;
   endfunction

   function automatic logic hit(input logic [17:0] addr, input logic [17:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction

   assign watchdog_enable_bit = device_configuration_word[sleep_wdt_pkg::wdt_en_pos];
   assign prescaler_assign_bit = prescaler_option_reg[sleep_wdt_pkg::psa_pos];
   assign prescale_rate = prescaler_option_reg[2:0];
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign sw_clear_wdt = do_write && hit(aw_addr, sleep_wdt_pkg::control_addr) && w_strb[0]
                         && w_data[sleep_wdt_pkg::ctrl_clrwdt_pos];
   assign do_sleep = (state == sleep_wdt_pkg::st_run) && sleep_instr;
   assign irq_events = {wdt_expire && state == sleep_wdt_pkg::st_sleep, wdt_expire, do_sleep};
   assign irq_clear = (do_write && hit(aw_addr, sleep_wdt_pkg::irq_clear_addr) && w_strb[0])
                      ? w_data[2:0] : 3'h0;

   // Watchdog tick: prescaler feeds the watchdog when assigned to it
   logic [7:0] tick_limit;
   always_comb begin
      tick_limit = prescaler_assign_bit ? (sleep_wdt_pkg::wdt_base_ticks >> (3'h7 - prescale_rate))
                                        : 8'h00;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || do_sleep || sw_clear_wdt || clear_wdt_instr || wdt_expire) begin
         prescale_count <= 8'h00;
      end else if (watchdog_enable_bit) begin
         prescale_count <= (prescale_count >= tick_limit) ? 8'h00 : prescale_count + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || do_sleep || sw_clear_wdt || clear_wdt_instr || wdt_expire) begin
         watchdog_counter <= '0;
      end else if (watchdog_enable_bit && prescale_count >= tick_limit) begin
         watchdog_counter <= watchdog_counter + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_expire <= 1'b0;
      end else begin
         wdt_expire <= watchdog_enable_bit && prescale_count >= tick_limit
                       && (&watchdog_counter) && !wdt_expire;
      end
   end

   // Power state sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= sleep_wdt_pkg::st_run;
      end else begin
         unique case (state)
            sleep_wdt_pkg::st_run: begin
               if (do_sleep) begin
                  state <= sleep_wdt_pkg::st_sleep;
               end
            end
            sleep_wdt_pkg::st_sleep: begin
               if (wdt_expire) begin
                  state <= sleep_wdt_pkg::st_wake;
               end
            end
            sleep_wdt_pkg::st_wake: begin
               state <= sleep_wdt_pkg::st_run;
            end
            default: begin
               state <= sleep_wdt_pkg::st_run;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_enable <= 1'b1;
      end else if (do_sleep) begin
         osc_enable <= 1'b0;
      end else if (state == sleep_wdt_pkg::st_sleep && wdt_expire) begin
         osc_enable <= 1'b1;
      end
   end

   // Processor status flags; the reset pin input is unused and its driver stays off
   always_ff @(posedge aclk) begin
      if (power_on) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end else if (do_sleep) begin
         power_down_flag <= 1'b0;
         timeout_flag <= 1'b1;
      end else if (wdt_expire) begin
         timeout_flag <= 1'b0;
      end else if (clear_wdt_instr || sw_clear_wdt) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_reset <= 1'b0;
         external_reset_pin_oe <= 1'b0;
      end else begin
         watchdog_reset <= wdt_expire && state != sleep_wdt_pkg::st_sleep;
         external_reset_pin_oe <= 1'b0;
      end
   end

   // Pins follow the core while running and freeze from the sleep instruction onward
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held <= '0;
      end else if (state == sleep_wdt_pkg::st_run && !do_sleep) begin
         held <= '{out: core_pin_out, oe: core_pin_oe};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
      end else if (state == sleep_wdt_pkg::st_run && !do_sleep) begin
         pin_out <= core_pin_out;
         pin_oe <= core_pin_oe;
      end else begin
         pin_out <= held.out;
         pin_oe <= held.oe;
      end
   end

   // Configuration word: loaded only by power-on, untouched by other resets
   always_ff @(posedge aclk) begin
      if (power_on) begin
         device_configuration_word <= sleep_wdt_pkg::config_default;
      end else if (do_write && hit(aw_addr, sleep_wdt_pkg::config_addr)) begin
         device_configuration_word <= merge_byte(device_configuration_word, w_data, w_strb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescaler_option_reg <= sleep_wdt_pkg::option_reset;
      end else if (do_write && (hit(aw_addr, sleep_wdt_pkg::option_addr)
                                || hit(aw_addr, sleep_wdt_pkg::option_mirror_addr))) begin
         prescaler_option_reg <= merge_byte(prescaler_option_reg, w_data, w_strb);
      end
   end

   // Interrupts: set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 3'h0;
         irq_enable <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
         if (do_write && hit(aw_addr, sleep_wdt_pkg::irq_enable_addr) && w_strb[0]) begin
            irq_enable <= w_data[2:0];
         end
         irq <= |(((irq_status & ~irq_clear) | irq_events) & irq_enable);
      end
   end

   // AXI4-Lite write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 18'h00000;
         w_full <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sleep_wdt_pkg::resp_okay;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (hit(aw_addr, sleep_wdt_pkg::option_addr)
                            || hit(aw_addr, sleep_wdt_pkg::option_mirror_addr)
                            || hit(aw_addr, sleep_wdt_pkg::config_addr)
                            || hit(aw_addr, sleep_wdt_pkg::irq_enable_addr)
                            || hit(aw_addr, sleep_wdt_pkg::irq_clear_addr)
                            || hit(aw_addr, sleep_wdt_pkg::control_addr))
                           ? sleep_wdt_pkg::resp_okay : sleep_wdt_pkg::resp_slverr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_full && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= sleep_wdt_pkg::resp_okay;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= sleep_wdt_pkg::resp_okay;
            s_axi_rdata <= 32'h00000000;
            if (hit(s_axi_araddr, sleep_wdt_pkg::option_addr)
                || hit(s_axi_araddr, sleep_wdt_pkg::option_mirror_addr)) begin
               s_axi_rdata <= {24'h000000, prescaler_option_reg};
            end else if (hit(s_axi_araddr, sleep_wdt_pkg::config_addr)) begin
               s_axi_rdata <= {24'h000000, device_configuration_word};
            end else if (hit(s_axi_araddr, sleep_wdt_pkg::status_addr)) begin
               s_axi_rdata <= {27'h0000000, timeout_flag, power_down_flag, 2'b00,
                               state == sleep_wdt_pkg::st_sleep};
            end else if (hit(s_axi_araddr, sleep_wdt_pkg::irq_status_addr)) begin
               s_axi_rdata <= {29'h00000000, irq_status};
            end else if (hit(s_axi_araddr, sleep_wdt_pkg::irq_enable_addr)) begin
               s_axi_rdata <= {29'h00000000, irq_enable};
            end else if (!hit(s_axi_araddr, sleep_wdt_pkg::irq_clear_addr)
                         && !hit(s_axi_araddr, sleep_wdt_pkg::control_addr)) begin
               s_axi_rresp <= sleep_wdt_pkg::resp_slverr;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   chk_sleep_cause: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(state == sleep_wdt_pkg::st_sleep) |-> $past(sleep_instr))
      else $error("Power-down entered without a request");
   chk_wdt_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
      do_sleep |=> watchdog_counter == '0)
      else $error("Watchdog not cleared on entry");
   chk_pd_cleared: assert property (@(posedge aclk) disable iff (!aresetn || power_on)
      do_sleep |=> !power_down_flag)
      else $error("Power-down flag not cleared");
   chk_to_set: assert property (@(posedge aclk) disable iff (!aresetn || power_on)
      do_sleep |=> timeout_flag)
      else $error("Time-out flag not set");
   chk_osc_off: assert property (@(posedge aclk) disable iff (!aresetn)
      do_sleep |=> !osc_enable ##1 !osc_enable || state != sleep_wdt_pkg::st_sleep)
      else $error("Oscillator still enabled in power-down");
   chk_pins_held: assert property (@(posedge aclk) disable iff (!aresetn)
      state == sleep_wdt_pkg::st_sleep && $past(state) == sleep_wdt_pkg::st_sleep
      |-> $stable(pin_out) && $stable(pin_oe))
      else $error("Pins moved in power-down");
   chk_pin_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      !external_reset_pin_oe)
      else $error("Reset pin driven");
   chk_option_reset: assert property (@(posedge aclk)
      !aresetn |=> prescaler_option_reg == sleep_wdt_pkg::option_reset)
      else $error("Option register reset value wrong");
   chk_wake: assert property (@(posedge aclk) disable iff (!aresetn)
      state == sleep_wdt_pkg::st_sleep && wdt_expire |=> osc_enable && !timeout_flag ##1
      state == sleep_wdt_pkg::st_run)
      else $error("No wake on watchdog expiry");
   cov_sleep: cover property (@(posedge aclk) disable iff (!aresetn) do_sleep);
   cov_wake: cover property (@(posedge aclk) disable iff (!aresetn)
      state == sleep_wdt_pkg::st_wake);
   cov_wdt_reset: cover property (@(posedge aclk) disable iff (!aresetn) watchdog_reset);
   cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule
`default_nettype wire

// File: sim/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic power_on = 1'b1;
   logic sleep_instr = 1'b0;
   logic clear_wdt_instr = 1'b0;
   logic external_reset_pin = 1'b1;
   logic [7:0] core_pin_out = 8'h00;
   logic [7:0] core_pin_oe = 8'h00;
   logic [17:0] s_axi_awaddr = 18'h00000;
   logic [17:0] s_axi_araddr = 18'h00000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] pin_out, pin_oe;
   logic osc_enable, watchdog_reset, external_reset_pin_oe, power_down_flag, timeout_flag, irq;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int t0;
   logic bad;
   localparam logic [1:0] okay = sleep_wdt_pkg::resp_okay;
   localparam logic [1:0] slverr = sleep_wdt_pkg::resp_slverr;

   sleep_and_watchdog_control #(.wdt_width(4)) i_sleep_and_watchdog_control (
      .aclk(aclk), .aresetn(aresetn), .sleep_instr(sleep_instr),
      .clear_wdt_instr(clear_wdt_instr), .power_on(power_on),
      .core_pin_out(core_pin_out), .core_pin_oe(core_pin_oe),
      .external_reset_pin(external_reset_pin),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .pin_out(pin_out), .pin_oe(pin_oe), .osc_enable(osc_enable),
      .watchdog_reset(watchdog_reset), .external_reset_pin_oe(external_reset_pin_oe),
      .power_down_flag(power_down_flag), .timeout_flag(timeout_flag), .irq(irq)
   );

   always #4 aclk = ~aclk;

   always @(posedge aclk) begin
      cyc <= cyc + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_busy;
      logic w_busy;
      aw_busy = 1'b1;
      w_busy = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (aw_busy && s_axi_awready === 1'b1) begin
            aw_busy = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_busy && s_axi_wready === 1'b1) begin
            w_busy = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (!aw_busy && !w_busy && s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      chk({30'h00000000, s_axi_bresp}, {30'h00000000, er});
   endtask

   task automatic rd(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic a_busy;
      a_busy = 1'b1;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (a_busy && s_axi_arready === 1'b1) begin
            a_busy = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (!a_busy && s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk({30'h00000000, s_axi_rresp}, {30'h00000000, er});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic test_end(input string name);
      $display("test %s done: comparisons=%0d n_fail=%0d", name, comparisons, n_fail);
   endtask

   task automatic wrap_up();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge aclk);
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 32'h00000000);
      wrap_up();
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      power_on <= 1'b0;
      t0 = cyc;
      // Registers, mirror and unmapped places
      rd(sleep_wdt_pkg::option_addr, 32'h000000FF, okay);
      rd(sleep_wdt_pkg::option_mirror_addr, 32'h000000FF, okay);
      rd(sleep_wdt_pkg::config_addr, 32'h000000FF, okay);
      rd(sleep_wdt_pkg::status_addr, 32'h00000018, okay);
      wr(sleep_wdt_pkg::option_mirror_addr, 32'h000000FA, okay);
      rd(sleep_wdt_pkg::option_addr, 32'h000000FA, okay);
      wr(sleep_wdt_pkg::option_addr, 32'h000000FF, okay);
      rd(18'h00100, 32'h00000000, slverr);
      wr(18'h00108, 32'h00000001, slverr);
      core_pin_out <= 8'h5A;
      core_pin_oe <= 8'hC3;
      settle(3);
      chk({16'h0000, pin_out, pin_oe}, 32'h00005AC3);
      chk({31'h00000000, osc_enable}, 32'h00000001);
      chk({31'h00000000, power_down_flag}, 32'h00000001);
      test_end("registers");
      // Sleep entry late in the watchdog period
      while (cyc - t0 < 3000) @(posedge aclk);
      core_pin_out <= 8'hA5;
      core_pin_oe <= 8'h3C;
      @(posedge aclk);
      sleep_instr <= 1'b1;
      @(posedge aclk);
      sleep_instr <= 1'b0;
      core_pin_out <= 8'h5A;
      core_pin_oe <= 8'hC3;
      t0 = cyc;
      @(negedge aclk);
      chk({31'h00000000, osc_enable}, 32'h00000000);
      chk({31'h00000000, power_down_flag}, 32'h00000000);
      chk({31'h00000000, timeout_flag}, 32'h00000001);
      settle(3);
      chk({16'h0000, pin_out, pin_oe}, 32'h0000A53C);
      chk({31'h00000000, external_reset_pin_oe}, 32'h00000000);
      rd(sleep_wdt_pkg::status_addr, 32'h00000011, okay);
      rd(sleep_wdt_pkg::irq_status_addr, 32'h00000001, okay);
      chk({31'h00000000, irq}, 32'h00000000);
      wr(sleep_wdt_pkg::irq_enable_addr, 32'h00000001, okay);
      settle(2);
      chk({31'h00000000, irq}, 32'h00000001);
      wr(sleep_wdt_pkg::irq_clear_addr, 32'h00000001, okay);
      settle(2);
      chk({31'h00000000, irq}, 32'h00000000);
      // Wake by watchdog expiry: counter was cleared at entry
      while (osc_enable !== 1'b1 && cyc - t0 < 6000) @(posedge aclk);
      chk({31'h00000000, (cyc - t0 >= 3500) && (cyc - t0 <= 4700)}, 32'h00000001);
      settle(3);
      chk({31'h00000000, timeout_flag}, 32'h00000000);
      chk({16'h0000, pin_out, pin_oe}, 32'h00005AC3);
      rd(sleep_wdt_pkg::irq_status_addr, 32'h00000006, okay);
      wr(sleep_wdt_pkg::irq_clear_addr, 32'h00000006, okay);
      rd(sleep_wdt_pkg::irq_status_addr, 32'h00000000, okay);
      test_end("sleep");
      // Watchdog expiry while running stays internal
      t0 = cyc;
      bad = 1'b0;
      while (watchdog_reset !== 1'b1 && cyc - t0 < 6000) begin
         @(posedge aclk);
         bad = bad | (external_reset_pin_oe !== 1'b0);
      end
      chk({31'h00000000, watchdog_reset}, 32'h00000001);
      chk({31'h00000000, bad}, 32'h00000000);
      chk({31'h00000000, cyc - t0 <= 4700}, 32'h00000001);
      test_end("expiry");
      // Control write clears the watchdog but never enters power-down
      wr(sleep_wdt_pkg::control_addr, 32'h00000003, okay);
      rd(sleep_wdt_pkg::status_addr, 32'h00000018, okay);
      chk({31'h00000000, osc_enable}, 32'h00000001);
      sleep_instr <= 1'b1;
      @(posedge aclk);
      sleep_instr <= 1'b0;
      t0 = cyc;
      @(negedge aclk);
      chk({31'h00000000, osc_enable}, 32'h00000000);
      while (osc_enable !== 1'b1 && cyc - t0 < 6000) @(posedge aclk);
      chk({31'h00000000, (cyc - t0 >= 3500) && (cyc - t0 <= 4700)}, 32'h00000001);
      rd(sleep_wdt_pkg::status_addr, 32'h00000000, okay);
      clear_wdt_instr <= 1'b1;
      @(posedge aclk);
      clear_wdt_instr <= 1'b0;
      rd(sleep_wdt_pkg::status_addr, 32'h00000018, okay);
      test_end("clear");
      // Configuration word survives reset, option does not
      wr(sleep_wdt_pkg::config_addr, 32'h000000FB, okay);
      wr(sleep_wdt_pkg::option_addr, 32'h00000000, okay);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(sleep_wdt_pkg::option_addr, 32'h000000FF, okay);
      rd(sleep_wdt_pkg::config_addr, 32'h000000FB, okay);
      t0 = cyc;
      bad = 1'b0;
      while (cyc - t0 < 4700) begin
         @(posedge aclk);
         bad = bad | (watchdog_reset !== 1'b0);
      end
      chk({31'h00000000, bad}, 32'h00000000);
      test_end("config");
      wrap_up();
   end
endmodule
`default_nettype wire
